// [verilog/cfa_params.svh]
`ifndef CFA_PARAMS_SVH
`define CFA_PARAMS_SVH

// ----------------------------------------------------------------
// Port structure
// ----------------------------------------------------------------
`define CFA_FIFO_NUM        6
`define CFA_DATA_W          32
`define CFA_SEL_W           3
`define CFA_ALMOST_WORDS    4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CFA_CLK_PERIOD_NS   5
`define CFA_FCLK_PERIOD_NS  20
`define CFA_FCLK_HALF       ((`CFA_FCLK_PERIOD_NS / `CFA_CLK_PERIOD_NS) / 2)
`define CFA_FB_TIMEOUT_NS   80
`define CFA_FB_TIMEOUT      (`CFA_FB_TIMEOUT_NS / `CFA_CLK_PERIOD_NS)

`endif

// [verilog/cfa_pkg.sv]
package cfa_pkg;

`include "cfa_params.svh"

    typedef logic [`CFA_SEL_W-1:0] cfa_sel_t;

    // Transfer state of one direction, advanced at each falling FIFO clock edge
    typedef enum logic [1:0] {
        CFA_XF_IDLE,
        CFA_XF_STREAM,
        CFA_XF_CHECK
    } cfa_xfer_e;

endpackage : cfa_pkg

// [verilog/cfa_fclk_gen.sv]
`timescale 1ns/1ps

module cfa_fclk_gen #(
    parameter int unsigned HALF       = 2,
    parameter int unsigned FB_TIMEOUT = 16
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Buffered copy of the FIFO clock
    input  wire logic i_fb,
    // Generated clock, edge events and return-clock status
    output logic      o_fclk,
    output logic      o_rise,
    output logic      o_fall,
    output logic      o_fb_ok
);

    logic [7:0] cnt;
    logic [7:0] fb_cnt;
    logic       fb_s1;
    logic       fb_s2;
    logic       fb_s3;
    logic [7:0] next_cnt;
    logic [7:0] next_fb_cnt;
    logic       next_fclk;
    logic       next_rise;
    logic       next_fall;
    logic       next_fb_ok;

    // ----------------------------------------------------------------
    // Divider and returned-clock watchdog
    // ----------------------------------------------------------------
    always_comb begin
        next_cnt  = cnt + 8'h01;
        next_fclk = o_fclk;
        if (cnt == 8'(HALF - 1)) begin
            next_cnt  = 8'h00;
            next_fclk = ~o_fclk;
        end
        next_rise   = next_fclk & ~o_fclk;
        next_fall   = ~next_fclk & o_fclk;
        // Edge taken from the second and third stages only
        next_fb_cnt = fb_cnt;
        if (fb_s2 != fb_s3) begin
            next_fb_cnt = 8'h00;
        end else if (fb_cnt != 8'(FB_TIMEOUT)) begin
            next_fb_cnt = fb_cnt + 8'h01;
        end
        next_fb_ok = (next_fb_cnt != 8'(FB_TIMEOUT));
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt     <= 8'h00;
            o_fclk  <= 1'b0;
            o_rise  <= 1'b0;
            o_fall  <= 1'b0;
            fb_s1   <= 1'b0;
            fb_s2   <= 1'b0;
            fb_s3   <= 1'b0;
            fb_cnt  <= 8'h00;
            o_fb_ok <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            o_fclk  <= next_fclk;
            o_rise  <= next_rise;
            o_fall  <= next_fall;
            fb_s1   <= i_fb;
            fb_s2   <= fb_s1;
            fb_s3   <= fb_s2;
            fb_cnt  <= next_fb_cnt;
            o_fb_ok <= next_fb_ok;
        end
    end

    property p_fclk_half;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_fclk != $past(o_fclk)) |-> ($past(cnt) == 8'(HALF - 1));
    endproperty
    a_fclk_half: assert property (p_fclk_half)
        else $error("FIFO clock toggled off its fixed half period");

endmodule : cfa_fclk_gen

// [verilog/cfa_fifo_port.sv]
`timescale 1ns/1ps

`include "cfa_params.svh"

// Contract
// - Up to six input and six output FIFOs are reached through one shared structure per direction.
// - The read side and the write side run independently and may transfer in the same cycle.
// - At most one input FIFO is read and at most one output FIFO is written per access.
// - Each direction gets its own continuously running fixed-frequency FIFO clock.
// - Each FIFO clock frequency stays inside the limits of the carrier in use.
// - Each FIFO has its own enable selecting it for the transfer at a FIFO clock edge.
// - At most one input FIFO has its output enable on at any time.
// - Read enable and output enable are timed to allow one 32-bit word per clock.
// - Reads stream while almost-empty is off, else one read then an empty check.
// - One common write bus drives all output FIFOs, one written at a time.
// - Write enable is timed to allow one 32-bit word per clock.
// - Writes stream while almost-full is off, else one write then a full check.
// - Buffered FIFO clocks return on clock inputs to follow the applied clock; here they only feed the o_in_fb_ok/o_out_fb_ok watchdogs.
// - Signals between unrelated clocks pass multi-stage synchronisers.
module cfa_fifo_port
    import cfa_pkg::*;
#(
    parameter int unsigned N_FIFO     = `CFA_FIFO_NUM,
    parameter int unsigned DATA_W     = `CFA_DATA_W,
    parameter int unsigned FCLK_HALF  = `CFA_FCLK_HALF,
    parameter int unsigned FB_TIMEOUT = `CFA_FB_TIMEOUT
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    // User read side
    input  wire logic              i_rd_req,
    input  wire cfa_pkg::cfa_sel_t i_rd_sel,
    output logic                   o_rd_valid,
    output cfa_pkg::cfa_sel_t      o_rd_sel,
    output logic [DATA_W-1:0]      o_rd_data,
    // User write side
    input  wire logic              i_wr_valid,
    input  wire cfa_pkg::cfa_sel_t i_wr_sel,
    input  wire logic [DATA_W-1:0] i_wr_data,
    output logic                   o_wr_ready,
    // Input FIFO pins
    output logic                   o_in_fclk,
    input  wire logic              i_in_fclk_fb,
    output logic [N_FIFO-1:0]      o_in_en,
    output logic                   o_in_ren,
    output logic [N_FIFO-1:0]      o_in_oe,
    input  wire logic [DATA_W-1:0] i_in_data,
    input  wire logic [N_FIFO-1:0] i_in_empty,
    input  wire logic [N_FIFO-1:0] i_in_aempty,
    // Output FIFO pins
    output logic                   o_out_fclk,
    input  wire logic              i_out_fclk_fb,
    output logic [N_FIFO-1:0]      o_out_en,
    output logic                   o_out_wen,
    output logic [DATA_W-1:0]      o_out_data,
    input  wire logic [N_FIFO-1:0] i_out_full,
    input  wire logic [N_FIFO-1:0] i_out_afull,
    // Status
    output logic                   o_in_fb_ok,
    output logic                   o_out_fb_ok
);

    import cfa_pkg::*;

    function automatic logic [N_FIFO-1:0] cfa_onehot(input cfa_sel_t s);
        logic [N_FIFO-1:0] v;
        v = '0;
        for (int i = 0; i < N_FIFO; i++) begin
            if (s == cfa_sel_t'(i)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction : cfa_onehot

    // ----------------------------------------------------------------
    // Reset release and clock generation
    // ----------------------------------------------------------------
    logic rst_s1;
    logic rst_n;
    logic in_rise;
    logic in_fall;
    logic out_rise;
    logic out_fall;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    cfa_fclk_gen #(.HALF(FCLK_HALF), .FB_TIMEOUT(FB_TIMEOUT)) u_in_clk (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_fb    (i_in_fclk_fb),
        .o_fclk  (o_in_fclk),
        .o_rise  (in_rise),
        .o_fall  (in_fall),
        .o_fb_ok (o_in_fb_ok)
    );

    cfa_fclk_gen #(.HALF(FCLK_HALF), .FB_TIMEOUT(FB_TIMEOUT)) u_out_clk (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_fb    (i_out_fclk_fb),
        .o_fclk  (o_out_fclk),
        .o_rise  (out_rise),
        .o_fall  (out_fall),
        .o_fb_ok (o_out_fb_ok)
    );

    // ----------------------------------------------------------------
    // Read side
    // ----------------------------------------------------------------
    cfa_xfer_e         rd_state;
    cfa_xfer_e         next_rd_state;
    logic [N_FIFO-1:0] in_empty_q;
    logic [N_FIFO-1:0] in_aempty_q;
    logic              rd_pend;
    cfa_sel_t          rd_sel_q;
    logic              rd_sel_ok;
    logic              rd_issue;
    logic              next_rd_pend;
    cfa_sel_t          next_rd_sel_q;
    logic [N_FIFO-1:0] next_in_en;
    logic [N_FIFO-1:0] next_in_oe;
    logic              next_in_ren;
    logic              next_rd_valid;
    logic [DATA_W-1:0] next_rd_data;
    cfa_sel_t          next_o_rd_sel;
    logic [N_FIFO-1:0] next_in_empty_q;
    logic [N_FIFO-1:0] next_in_aempty_q;

    always_comb begin
        rd_sel_ok = (i_rd_sel < cfa_sel_t'(N_FIFO));
        // A switch of FIFO waits until a FIFO clock edge has passed with no read
        rd_issue  = in_fall && i_rd_req && rd_sel_ok && !in_empty_q[i_rd_sel]
                    && (rd_state != CFA_XF_CHECK)
                    && (!rd_pend || i_rd_sel == rd_sel_q);
        next_rd_state    = rd_state;
        next_in_en       = o_in_en;
        next_in_oe       = o_in_oe;
        next_in_ren      = o_in_ren;
        next_rd_sel_q    = rd_sel_q;
        next_rd_pend     = rd_pend;
        next_rd_valid    = 1'b0;
        next_rd_data     = o_rd_data;
        next_o_rd_sel    = o_rd_sel;
        next_in_empty_q  = in_empty_q;
        next_in_aempty_q = in_aempty_q;
        if (in_fall) begin
            next_in_ren = rd_issue;
            next_in_en  = rd_issue ? cfa_onehot(i_rd_sel) : '0;
            next_in_oe  = rd_issue ? cfa_onehot(i_rd_sel) :
                          (rd_pend ? cfa_onehot(rd_sel_q) : '0);
            if (rd_issue) begin
                next_rd_sel_q = i_rd_sel;
                next_rd_state = in_aempty_q[i_rd_sel] ? CFA_XF_CHECK : CFA_XF_STREAM;
            end else begin
                next_rd_state = CFA_XF_IDLE;
            end
        end
        if (in_rise) begin
            next_in_empty_q  = i_in_empty;
            next_in_aempty_q = i_in_aempty;
            next_rd_pend     = o_in_ren;
            // Take the word read at this edge now: streaming replaces it at the next edge
            if (o_in_ren) begin
                next_rd_valid = 1'b1;
                next_rd_data  = i_in_data;
                next_o_rd_sel = rd_sel_q;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state    <= CFA_XF_IDLE;
            o_in_en     <= '0;
            o_in_oe     <= '0;
            o_in_ren    <= 1'b0;
            rd_sel_q    <= '0;
            rd_pend     <= 1'b0;
            o_rd_valid  <= 1'b0;
            o_rd_data   <= '0;
            o_rd_sel    <= '0;
            in_empty_q  <= '1;
            in_aempty_q <= '1;
        end else begin
            rd_state    <= next_rd_state;
            o_in_en     <= next_in_en;
            o_in_oe     <= next_in_oe;
            o_in_ren    <= next_in_ren;
            rd_sel_q    <= next_rd_sel_q;
            rd_pend     <= next_rd_pend;
            o_rd_valid  <= next_rd_valid;
            o_rd_data   <= next_rd_data;
            o_rd_sel    <= next_o_rd_sel;
            in_empty_q  <= next_in_empty_q;
            in_aempty_q <= next_in_aempty_q;
        end
    end

    // ----------------------------------------------------------------
    // Write side, independent of the read side
    // ----------------------------------------------------------------
    cfa_xfer_e         wr_state;
    cfa_xfer_e         next_wr_state;
    logic [N_FIFO-1:0] out_full_q;
    logic [N_FIFO-1:0] out_afull_q;
    logic              wr_issue;
    logic [N_FIFO-1:0] next_out_en;
    logic              next_out_wen;
    logic [DATA_W-1:0] next_out_data;
    logic [N_FIFO-1:0] next_out_full_q;
    logic [N_FIFO-1:0] next_out_afull_q;

    always_comb begin
        wr_issue = out_fall && i_wr_valid && (i_wr_sel < cfa_sel_t'(N_FIFO))
                   && !out_full_q[i_wr_sel] && (wr_state != CFA_XF_CHECK);
        next_wr_state    = wr_state;
        next_out_en      = o_out_en;
        next_out_wen     = o_out_wen;
        next_out_data    = o_out_data;
        next_out_full_q  = out_full_q;
        next_out_afull_q = out_afull_q;
        if (out_fall) begin
            next_out_wen = wr_issue;
            next_out_en  = wr_issue ? cfa_onehot(i_wr_sel) : '0;
            if (wr_issue) begin
                next_out_data = i_wr_data;
                next_wr_state = out_afull_q[i_wr_sel] ? CFA_XF_CHECK : CFA_XF_STREAM;
            end else begin
                next_wr_state = CFA_XF_IDLE;
            end
        end
        if (out_rise) begin
            next_out_full_q  = i_out_full;
            next_out_afull_q = i_out_afull;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state    <= CFA_XF_IDLE;
            o_out_en    <= '0;
            o_out_wen   <= 1'b0;
            o_out_data  <= '0;
            o_wr_ready  <= 1'b0;
            out_full_q  <= '1;
            out_afull_q <= '1;
        end else begin
            wr_state    <= next_wr_state;
            o_out_en    <= next_out_en;
            o_out_wen   <= next_out_wen;
            o_out_data  <= next_out_data;
            o_wr_ready  <= wr_issue;
            out_full_q  <= next_out_full_q;
            out_afull_q <= next_out_afull_q;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_in_en_one;
        @(posedge i_clk) disable iff (!rst_n) $onehot0(o_in_en);
    endproperty
    a_in_en_one: assert property (p_in_en_one)
        else $error("More than one input FIFO enabled");

    property p_in_oe_one;
        @(posedge i_clk) disable iff (!rst_n) $onehot0(o_in_oe);
    endproperty
    a_in_oe_one: assert property (p_in_oe_one)
        else $error("More than one input FIFO output enable on");

    property p_out_en_one;
        @(posedge i_clk) disable iff (!rst_n) $onehot0(o_out_en);
    endproperty
    a_out_en_one: assert property (p_out_en_one)
        else $error("More than one output FIFO enabled");

    property p_reset_quiet;
        @(posedge i_clk) disable iff (!i_reset_n)
        !rst_n |-> (o_in_en == '0 && o_out_en == '0 && !o_in_ren && !o_out_wen);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("Enable active during reset");

    property p_en_at_fall;
        @(posedge i_clk) disable iff (!rst_n)
        $changed(o_in_en) |-> $past(in_fall);
    endproperty
    a_en_at_fall: assert property (p_en_at_fall)
        else $error("Input enable changed away from a falling FIFO clock");

    property p_rd_single;
        @(posedge i_clk) disable iff (!rst_n)
        (in_fall && $past(rd_issue && in_aempty_q[i_rd_sel], FCLK_HALF * 2)) |-> !rd_issue;
    endproperty
    a_rd_single: assert property (p_rd_single)
        else $error("Read repeated without an empty check after almost-empty");

    property p_rd_capture;
        @(posedge i_clk) disable iff (!rst_n)
        (in_rise && o_in_ren) |=> (o_rd_valid && o_rd_data == $past(i_in_data));
    endproperty
    a_rd_capture: assert property (p_rd_capture)
        else $error("Read word not delivered");

    property p_wr_full;
        @(posedge i_clk) disable iff (!rst_n)
        $rose(o_wr_ready) |-> $past(!out_full_q[i_wr_sel] && out_fall);
    endproperty
    a_wr_full: assert property (p_wr_full)
        else $error("Write accepted into a full FIFO");

    property p_wr_pins;
        @(posedge i_clk) disable iff (!rst_n)
        o_wr_ready |-> (o_out_wen && o_out_data == $past(i_wr_data));
    endproperty
    a_wr_pins: assert property (p_wr_pins)
        else $error("Accepted word not on the output bus");

endmodule : cfa_fifo_port

// [verif/cfa_carrier_model.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Carrier FIFOs: six readable and six writable, one shared bus each
// ----------------------------------------------------------------
module cfa_carrier_model #(
    parameter int unsigned N = 6
) (
    // Input FIFO side
    input  wire logic         i_in_fclk,
    input  wire logic [N-1:0] i_in_en,
    input  wire logic         i_in_ren,
    input  wire logic [N-1:0] i_in_oe,
    output logic [31:0]       o_in_data,
    output logic [N-1:0]      o_in_empty,
    output logic [N-1:0]      o_in_aempty,
    // Output FIFO side
    input  wire logic         i_out_fclk,
    input  wire logic [N-1:0] i_out_en,
    input  wire logic         i_out_wen,
    input  wire logic [31:0]  i_out_data,
    output logic [N-1:0]      o_out_full,
    output logic [N-1:0]      o_out_afull
);
    int          in_cnt [N];
    int          in_seq [N];
    int          out_cnt [N];
    int          out_cap [N];
    logic [31:0] out_q [N][$];
    logic [31:0] dout [N];
    logic [31:0] bus_last;
    int          n_bad;

    initial begin
        n_bad    = 0;
        bus_last = 32'h0;
        for (int i = 0; i < N; i++) begin
            in_cnt[i]  = 0;
            in_seq[i]  = 0;
            out_cnt[i] = 0;
            out_cap[i] = 64;
            dout[i]    = 32'h0;
        end
    end

    task automatic load_in(input int f, input int n);
        in_cnt[f] = n;
        in_seq[f] = 0;
    endtask : load_in

    task automatic set_cap(input int f, input int c);
        out_cap[f] = c;
        out_cnt[f] = 0;
        out_q[f].delete();
    endtask : set_cap

    // Flags follow the fill level at once, like a FIFO's own flag logic
    always_comb begin
        for (int i = 0; i < N; i++) begin
            o_in_empty[i]  = (in_cnt[i] == 0);
            o_in_aempty[i] = (in_cnt[i] <= 4);
            o_out_full[i]  = (out_cnt[i] >= out_cap[i]);
            o_out_afull[i] = (out_cap[i] - out_cnt[i] <= 4);
        end
    end

    // A read of an empty FIFO or of two at once is counted as misuse
    always @(posedge i_in_fclk) begin
        if (i_in_ren && $countones(i_in_en) > 1) begin
            n_bad++;
        end
        for (int i = 0; i < N; i++) begin
            if (i_in_en[i] && i_in_ren) begin
                if (in_cnt[i] == 0) begin
                    n_bad++;
                end else begin
                    dout[i] <= {8'(i), 8'h5a, 16'(in_seq[i])};
                    in_seq[i]++;
                    in_cnt[i]--;
                end
            end
        end
        bus_last <= o_in_data;
    end

    // Released bus shows a pattern that flips each FIFO clock: the last word inverted, then the word again
    always_comb begin
        o_in_data = ~bus_last;
        for (int i = 0; i < N; i++) begin
            if (i_in_oe[i]) begin
                o_in_data = dout[i];
            end
        end
    end

    always @(posedge i_out_fclk) begin
        for (int i = 0; i < N; i++) begin
            if (i_out_wen && i_out_en[i]) begin
                if (out_cnt[i] >= out_cap[i]) begin
                    n_bad++;
                end else begin
                    out_q[i].push_back(i_out_data);
                    out_cnt[i]++;
                end
            end
        end
    end
endmodule : cfa_carrier_model

// [verif/cfa_fifo_port_tb.sv]
`timescale 1ns/1ps

module cfa_fifo_port_tb;
    import cfa_pkg::*;
    localparam int unsigned HALF = 2;
    logic             i_clk, i_reset_n, i_rd_req, i_wr_valid, o_rd_valid, o_wr_ready;
    cfa_sel_t         i_rd_sel, i_wr_sel, o_rd_sel;
    logic [31:0]      i_wr_data, o_rd_data, in_data, out_data;
    logic             in_fclk, in_fb, in_ren, out_fclk, out_fb, out_wen, in_ok, out_ok;
    logic [5:0]       in_en, in_oe, in_empty, in_aempty, out_en, out_full, out_afull;
    int               n_errors, tests_run;

    cfa_fifo_port #(.FCLK_HALF(HALF)) dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_rd_req(i_rd_req), .i_rd_sel(i_rd_sel),
        .o_rd_valid(o_rd_valid), .o_rd_sel(o_rd_sel), .o_rd_data(o_rd_data),
        .i_wr_valid(i_wr_valid), .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data),
        .o_wr_ready(o_wr_ready), .o_in_fclk(in_fclk), .i_in_fclk_fb(in_fb),
        .o_in_en(in_en), .o_in_ren(in_ren), .o_in_oe(in_oe), .i_in_data(in_data),
        .i_in_empty(in_empty), .i_in_aempty(in_aempty), .o_out_fclk(out_fclk),
        .i_out_fclk_fb(out_fb), .o_out_en(out_en), .o_out_wen(out_wen),
        .o_out_data(out_data), .i_out_full(out_full), .i_out_afull(out_afull),
        .o_in_fb_ok(in_ok), .o_out_fb_ok(out_ok));

    cfa_carrier_model model (
        .i_in_fclk(in_fclk), .i_in_en(in_en), .i_in_ren(in_ren), .i_in_oe(in_oe),
        .o_in_data(in_data), .o_in_empty(in_empty), .o_in_aempty(in_aempty),
        .i_out_fclk(out_fclk), .i_out_en(out_en), .i_out_wen(out_wen),
        .i_out_data(out_data), .o_out_full(out_full), .o_out_afull(out_afull));

    // External clock buffer delay on the return path
    assign #1 in_fb  = in_fclk;
    assign #1 out_fb = out_fclk;

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_flag

    task automatic test_done;
        $display("errors %0d, comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic fclk_period(input int side);
        int t = 0;
        for (int p = 0; p < 3; p++) begin
            @(posedge (side == 0 ? in_fclk : out_fclk));
            t = 0;
            while (t < 50) begin
                @(posedge i_clk);
                t++;
                #1;
                if ((side == 0 ? in_fclk : out_fclk) === 1'b1 && t > 1) break;
            end
            chk_val(t, 2 * HALF, "fifo clock period");
        end
        chk_flag(side == 0 ? in_ok : out_ok, 1'b1, "return clock seen");
    endtask : fclk_period

    task automatic read_words(input int f, input int n);
        int k = 0;
        int t = 0;
        int t_prev = 0;
        model.load_in(f, n);
        @(posedge i_clk);
        i_rd_req <= 1'b1;
        i_rd_sel <= 3'(f);
        while (k < n && t < 40 * n + 100) begin
            @(posedge i_clk);
            t++;
            #1;
            if (o_rd_valid === 1'b1) begin
                chk_val(o_rd_data, {8'(f), 8'h5a, 16'(k)}, "read word");
                chk_val(32'(o_rd_sel), 32'(f), "read source");
                if (k == 1 && n >= 12) chk_val(t - t_prev, 2 * HALF, "read rate");
                t_prev = t;
                k++;
            end
        end
        repeat (40) begin
            @(posedge i_clk);
            #1;
            if (o_rd_valid === 1'b1) k++;
        end
        chk_val(k, n, "words read");
        i_rd_req <= 1'b0;
        chk_val(model.n_bad, 0, "carrier misuse");
    endtask : read_words

    task automatic write_words(input int f, input int n, input int cap, input int exp_acc);
        int acc = 0;
        int t = 0;
        int t_prev = 0;
        logic got;
        model.set_cap(f, cap);
        for (int w = 0; w < n; w++) begin
            @(posedge i_clk);
            i_wr_valid <= 1'b1;
            i_wr_sel   <= 3'(f);
            i_wr_data  <= {8'(f), 8'ha5, 16'(w)};
            got = 1'b0;
            t   = 0;
            while (!got && t < 60) begin
                @(posedge i_clk);
                t++;
                #1;
                got = (o_wr_ready === 1'b1);
            end
            if (!got) break;
            if (acc == 1 && n >= 12) chk_val(t + 1, 2 * HALF, "write rate");
            acc++;
        end
        @(posedge i_clk);
        i_wr_valid <= 1'b0;
        repeat (12) @(posedge i_clk);
        chk_val(acc, exp_acc, "words accepted");
        chk_val(model.out_cnt[f], exp_acc, "words stored");
        for (int k = 0; k < acc; k++) begin
            chk_val(model.out_q[f][k], {8'(f), 8'ha5, 16'(k)}, "stored word");
        end
        chk_val(model.n_bad, 0, "carrier misuse");
    endtask : write_words

    task automatic bad_select;
        int hits = 0;
        @(posedge i_clk);
        i_rd_req   <= 1'b1;
        i_rd_sel   <= 3'd6;
        i_wr_valid <= 1'b1;
        i_wr_sel   <= 3'd7;
        repeat (40) begin
            @(posedge i_clk);
            #1;
            if (in_en !== 6'h0 || o_rd_valid !== 1'b0 || o_wr_ready !== 1'b0) hits++;
        end
        chk_val(hits, 0, "no access to absent fifo");
        i_rd_req   <= 1'b0;
        i_wr_valid <= 1'b0;
    endtask : bad_select

    // Shared pins: one selected per direction, seen between clock edges
    always @(negedge i_clk) begin
        if (i_reset_n) begin
            chk_flag($countones(in_oe) <= 1, 1'b1, "input output enables");
            chk_flag($countones(in_en) <= 1, 1'b1, "input enables");
            chk_flag($countones(out_en) <= 1, 1'b1, "output enables");
        end
    end

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        $display("CHECK FAILED at %0t: run did not finish in time", $time);
        test_done();
    end

    initial begin
        n_errors   = 0;
        tests_run  = 0;
        i_reset_n  = 1'b0;
        i_rd_req   = 1'b0;
        i_rd_sel   = 3'd0;
        i_wr_valid = 1'b0;
        i_wr_sel   = 3'd0;
        i_wr_data  = 32'h0;
        repeat (12) @(posedge i_clk);
        #1;
        chk_val({26'h0, in_en} | {26'h0, out_en}, 32'h0, "enables in reset");
        chk_flag(in_ren | out_wen, 1'b0, "strobes in reset");
        chk_flag(in_fclk | out_fclk, 1'b0, "fifo clocks in reset");
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        fclk_period(0);
        fclk_period(1);
        fork
            read_words(1, 12);
            write_words(3, 12, 64, 12);
        join
        write_words(4, 8, 6, 6);
        bad_select();
        for (int i = 0; i < 6; i++) begin
            fork
                read_words(i, 5);
                write_words(i, 5, 64, 5);
            join
        end
        test_done();
    end
endmodule : cfa_fifo_port_tb
